// ==== smm_map.vh ====
`ifndef SMM_MAP_VH
`define SMM_MAP_VH
`define CMD_PTR_A_LOC    16'h0102
`define DATA_PTR_A_LOC   16'h0103
`define CMD_PTR_B_LOC    16'h0106
`define DATA_PTR_B_LOC   16'h0107
`define LOOKUP_BASE      16'h0280
`define LOOKUP_LAST      16'h02FF
`define ISQ_BASE         16'h0040
`define ISQ_PTR_W        6
`define ISQ_PTR_RST      6'h00
`define DESC_WORDS       3'h4
`define EVT_EOM          16'h0001
`define EVT_ERR          16'h0002
`define EVT_PARITY       16'h0004
`define FIFO_WIDTH       17
`define FIFO_DEPTH       8
`define MAX_WC           16'h0021
`define MAX_WC_RTRT      16'h0023
`endif

// ==== smm_fifo.v ====
`timescale 1ns/1ps
module smm_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_reg;
  reg [AW:0]      rd_reg;
  wire            full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire            empty = (wr_reg == rd_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_reg[AW-1:0]];
  always @(posedge clk) begin
    if (in_valid && !full)
      mem[wr_reg[AW-1:0]] <= in_data;
  end
  always @(posedge clk) begin
    if (!resetn) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wr_reg <= wr_reg + 1'b1;
      if (out_ready && !empty)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule

// ==== selective_message_monitor.v ====
`include "smm_map.vh"
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module selective_message_monitor (
  input  wire        clk,
  input  wire        resetn,
  input  wire        enable,
  input  wire        combined_mode,
  input  wire [4:0]  own_rt_addr,
  input  wire        area_b,
  input  wire [1:0]  cmd_stack_size,
  input  wire [2:0]  data_stack_size,
  input  wire        isq_enable,
  input  wire [1:0]  isq_filter,
  input  wire [4:0]  int_mask,
  input  wire [15:0] word_data,
  input  wire        word_is_cmd_sync,
  input  wire        word_valid,
  input  wire        word_error,
  input  wire        bus_idle,
  input  wire        ram_parity_err,
  input  wire [15:0] ram_parity_addr,
  output reg  [15:0] ram_addr,
  output reg  [15:0] ram_wdata,
  output reg         ram_we,
  output reg         ram_re,
  input  wire [15:0] ram_rdata,
  input  wire        ram_ack,
  output reg         irq,
  output reg  [4:0]  event_pulse,
  output reg         busy
);
  localparam S_IDLE   = 4'd0;
  localparam S_RDCP   = 4'd1;
  localparam S_RDDP   = 4'd2;
  localparam S_LOOK   = 4'd3;
  localparam S_COLL   = 4'd4;
  localparam S_DESC   = 4'd5;
  localparam S_DRAIN  = 4'd6;
  localparam S_WBCP   = 4'd7;
  localparam S_WBDP   = 4'd8;
  localparam S_ISQ0   = 4'd9;
  localparam S_ISQ1   = 4'd10;

  // lookup word address
  function [15:0] lookup_addr;
    input [15:0] cmd;
    begin
      lookup_addr = `LOOKUP_BASE | {9'h000, cmd[15:11], cmd[10], cmd[9]};
    end
  endfunction

  function [15:0] cmd_len;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    cmd_len = 16'h0100;
        2'd1:    cmd_len = 16'h0400;
        2'd2:    cmd_len = 16'h1000;
        default: cmd_len = 16'h4000;
      endcase
    end
  endfunction

  function [16:0] data_len;
    input [2:0] sel;
    begin
      data_len = 17'h0_0200 << sel;
    end
  endfunction

  reg [3:0]  state_reg;
  reg [15:0] cmd_reg;
  reg [15:0] cmd_ptr_reg;
  reg [15:0] data_ptr_reg;
  reg [15:0] cmd_base_reg;
  reg [15:0] data_base_reg;
  reg [15:0] first_data_reg;
  reg [15:0] wcount_reg;
  reg        err_reg;
  reg        rtrt_seen_reg;
  reg        parity_pend_reg;
  reg [15:0] parity_addr_reg;
  reg [15:0] parity_log_reg;
  reg [2:0]  desc_idx_reg;
  reg [5:0]  isq_ptr_reg;
  reg        parity_entry_reg;

  wire [15:0] clen   = cmd_len(cmd_stack_size);
  wire [16:0] dlen   = data_len(data_stack_size);
  wire [15:0] dlen16 = dlen[15:0];
  wire [15:0] cp_loc = area_b ? `CMD_PTR_B_LOC : `CMD_PTR_A_LOC;
  wire [15:0] dp_loc = area_b ? `DATA_PTR_B_LOC : `DATA_PTR_A_LOC;
  wire [4:0]  rt_of  = word_data[15:11];
  wire        own_hit = combined_mode && (rt_of == own_rt_addr || rt_of == 5'h1F);

  // every word received while collecting (S_COLL), status and second command included, buffered for RAM while the fifo has room
  wire [16:0] f_out;
  wire        f_valid;
  wire        f_ready;
  reg         f_pop;
  wire        f_push = (state_reg == S_COLL) && word_valid;
  smm_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(3)) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   ({word_error, word_data}),
    .in_valid  (f_push),
    .in_ready  (f_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // pointer offset within the stack, for midpoint/wrap detection
  wire [15:0] d_off  = (data_ptr_reg - data_base_reg) & (dlen16 - 16'h0001);
  wire [15:0] c_off  = (cmd_ptr_reg - cmd_base_reg) & (clen - 16'h0001);
  wire [15:0] dlenm  = dlen16 - 16'h0001;

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!resetn) begin
      state_reg        <= S_IDLE;
      cmd_reg          <= 16'h0000;
      cmd_ptr_reg      <= 16'h0000;
      data_ptr_reg     <= 16'h0000;
      cmd_base_reg     <= 16'h0000;
      data_base_reg    <= 16'h0000;
      first_data_reg   <= 16'h0000;
      wcount_reg       <= 16'h0000;
      err_reg          <= 1'b0;
      rtrt_seen_reg    <= 1'b0;
      parity_pend_reg  <= 1'b0;
      parity_addr_reg  <= 16'h0000;
      parity_log_reg   <= 16'h0000;
      desc_idx_reg     <= 3'h0;
      isq_ptr_reg      <= `ISQ_PTR_RST;
      parity_entry_reg <= 1'b0;
      ram_addr         <= 16'h0000;
      ram_wdata        <= 16'h0000;
      ram_we           <= 1'b0;
      ram_re           <= 1'b0;
      irq              <= 1'b0;
      event_pulse      <= 5'h00;
      busy             <= 1'b0;
      f_pop            <= 1'b0;
    end else begin
      event_pulse <= 5'h00;
      f_pop       <= 1'b0;
      // a new parity error outranks the clear taken in idle
      if (ram_parity_err) begin
        parity_pend_reg <= 1'b1;
        parity_addr_reg <= ram_parity_addr;
      end
      busy <= (state_reg != S_IDLE);
      case (state_reg)
        S_IDLE: begin
          ram_we <= 1'b0;
          ram_re <= 1'b0;
          if (parity_pend_reg && isq_enable) begin
            parity_pend_reg  <= ram_parity_err;
            parity_log_reg   <= parity_addr_reg;
            parity_entry_reg <= 1'b1;
            state_reg        <= S_ISQ0;
          end else if (enable && word_valid && word_is_cmd_sync && !word_error && !own_hit) begin
            cmd_reg       <= word_data;
            err_reg       <= 1'b0;
            rtrt_seen_reg <= 1'b0;
            wcount_reg    <= 16'h0000;
            ram_addr      <= lookup_addr(word_data);
            ram_re        <= 1'b1;
            state_reg     <= S_LOOK;
          end
        end
        S_LOOK: begin
          if (ram_ack) begin
            ram_re <= 1'b0;
            if (ram_rdata[cmd_reg[8:5]]) begin
              ram_addr  <= cp_loc;
              ram_re    <= 1'b1;
              state_reg <= S_RDCP;
            end else begin
              state_reg <= S_IDLE;
            end
          end
        end
        S_RDCP: begin
          if (ram_ack) begin
            cmd_ptr_reg  <= ram_rdata;
            // stack start is the pointer rounded down to the stack length
            cmd_base_reg <= ram_rdata & ~(clen - 16'h0001);
            ram_addr     <= dp_loc;
            state_reg    <= S_RDDP;
          end
        end
        S_RDDP: begin
          if (ram_ack) begin
            ram_re        <= 1'b0;
            data_ptr_reg  <= ram_rdata;
            first_data_reg<= ram_rdata;
            data_base_reg <= ram_rdata & ~dlenm;
            state_reg     <= S_COLL;
          end
        end
        S_COLL: begin
          if (word_valid && word_is_cmd_sync && !rtrt_seen_reg && !cmd_reg[10]
              && wcount_reg == 16'h0000) begin
            rtrt_seen_reg <= 1'b1;
          end
          if (word_valid && word_error)
            err_reg <= 1'b1;
          if (f_push && !f_ready)
            err_reg <= 1'b1;
          if (f_push)
            wcount_reg <= wcount_reg + 16'h0001;
          // one stack write at a time, held until the ram acknowledges
          if (ram_we) begin
            if (ram_ack) begin
              ram_we       <= 1'b0;
              data_ptr_reg <= (d_off == dlenm) ? data_base_reg : data_ptr_reg + 16'h0001;
              if (d_off == dlenm)
                event_pulse[4] <= int_mask[4];
              if (d_off == dlen[16:1] - 16'h0001)
                event_pulse[3] <= int_mask[3];
            end
          end else if (f_valid && !f_pop) begin
            ram_addr  <= data_ptr_reg;
            ram_wdata <= f_out[15:0];
            ram_we    <= 1'b1;
            f_pop     <= 1'b1;
            if (f_out[16])
              err_reg <= 1'b1;
          end
          if (bus_idle && !f_valid && !ram_we && !f_pop) begin
            desc_idx_reg <= 3'h0;
            if (wcount_reg == 16'h0000
                || wcount_reg > (rtrt_seen_reg ? `MAX_WC_RTRT : `MAX_WC))
              err_reg <= 1'b1;
            state_reg <= S_DESC;
          end
        end
        S_DESC: begin
          // each descriptor word is held until acknowledged
          if (!ram_we || ram_ack) begin
            if (desc_idx_reg == `DESC_WORDS) begin
              ram_we    <= 1'b0;
              state_reg <= S_WBCP;
            end else begin
              ram_addr  <= cmd_ptr_reg;
              ram_we    <= 1'b1;
              case (desc_idx_reg)
                3'h0:    ram_wdata <= {15'h0000, err_reg};
                3'h1:    ram_wdata <= wcount_reg;
                3'h2:    ram_wdata <= first_data_reg;
                default: ram_wdata <= cmd_reg;
              endcase
              desc_idx_reg <= desc_idx_reg + 3'h1;
              cmd_ptr_reg  <= (c_off == clen - 16'h0001) ? cmd_base_reg
                                                        : cmd_ptr_reg + 16'h0001;
              if (c_off == clen - 16'h0001)
                event_pulse[2] <= int_mask[2];
              if (c_off == (clen >> 1) - 16'h0001)
                event_pulse[1] <= int_mask[1];
            end
          end
        end
        S_WBCP: begin
          // pointers go back to ram before end of message is signalled
          ram_addr  <= cp_loc;
          ram_wdata <= cmd_ptr_reg;
          ram_we    <= 1'b1;
          state_reg <= S_WBDP;
        end
        S_WBDP: begin
          if (ram_ack) begin
            ram_addr  <= dp_loc;
            ram_wdata <= data_ptr_reg;
            state_reg <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          if (ram_ack) begin
            ram_we         <= 1'b0;
            event_pulse[0] <= int_mask[0];
            state_reg      <= (isq_enable && (err_reg ? isq_filter[1] : isq_filter[0]))
                              ? S_ISQ0 : S_IDLE;
          end
        end
        S_ISQ0: begin
          ram_addr  <= `ISQ_BASE | {10'h000, isq_ptr_reg};
          ram_wdata <= parity_entry_reg ? `EVT_PARITY : (err_reg ? `EVT_ERR : `EVT_EOM);
          ram_we    <= 1'b1;
          state_reg <= S_ISQ1;
        end
        S_ISQ1: begin
          if (ram_ack) begin
            if (ram_addr[0]) begin
              ram_we           <= 1'b0;
              parity_entry_reg <= 1'b0;
              isq_ptr_reg      <= isq_ptr_reg + 6'h02;
              state_reg        <= S_IDLE;
            end else begin
              // second word of the entry: command, or the failing ram address
              ram_addr  <= ram_addr + 16'h0001;
              ram_wdata <= parity_entry_reg ? parity_log_reg : cmd_reg;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      irq <= |event_pulse;
    end
  end
endmodule

// ==== smm_check_monitor.sv ====
`timescale 1ns/1ps
module smm_check (
  input wire        clk,
  input wire        resetn,
  input wire        enable,
  input wire [4:0]  int_mask,
  input wire [15:0] ram_addr,
  input wire [15:0] ram_wdata,
  input wire        ram_we,
  input wire        ram_re,
  input wire        ram_ack,
  input wire        irq,
  input wire [4:0]  event_pulse,
  input wire        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // cycles since the last pointer write-back to 0102/0103/0106/0107
  reg [3:0] since_ptr_reg;
  always @(posedge clk) begin
    if (!resetn)
      since_ptr_reg <= 4'hf;
    else if (ram_we && ram_ack && ram_addr[15:3] == 13'h0020 && ram_addr[1])
      since_ptr_reg <= 4'h0;
    else if (since_ptr_reg != 4'hf)
      since_ptr_reg <= since_ptr_reg + 4'h1;
  end
  property p_one_access; !(ram_re && ram_we); endproperty
  a_one_access: assert property (p_one_access) else $error("read and write at once");
  property p_read_hold; ram_re && !ram_ack |=> ram_re && $stable(ram_addr); endproperty
  a_read_hold: assert property (p_read_hold) else $error("read dropped early");
  property p_write_hold;
    ram_we && !ram_ack |=> ram_we && $stable(ram_addr) && $stable(ram_wdata);
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write dropped early");
  property p_masked; (event_pulse & ~int_mask) == 5'h00; endproperty
  a_masked: assert property (p_masked) else $error("masked event fired");
  property p_table_ro; ram_we |-> (ram_addr < 16'h0280 || ram_addr > 16'h02ff); endproperty
  a_table_ro: assert property (p_table_ro) else $error("write into lookup table");
  property p_quiet_off; !enable && !busy |-> !ram_re && !ram_we; endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("ram access while off");
  property p_eom_after_ptr; event_pulse[0] |-> since_ptr_reg < 4'h8; endproperty
  a_eom_after_ptr: assert property (p_eom_after_ptr) else $error("eom without write-back");
  property p_irq_cause; irq |-> event_pulse != 5'h00 || $past(event_pulse) != 5'h00; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
endmodule
bind selective_message_monitor smm_check u_smm_check (
  .clk(clk), .resetn(resetn), .enable(enable), .int_mask(int_mask), .ram_addr(ram_addr),
  .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re), .ram_ack(ram_ack), .irq(irq),
  .event_pulse(event_pulse), .busy(busy));

// ==== smm_ram.sv ====
`timescale 1ns/1ps
module smm_ram (
  input  wire        clk,
  input  wire        slow,
  input  wire [15:0] ram_addr,
  input  wire [15:0] ram_wdata,
  input  wire        ram_we,
  input  wire        ram_re,
  output reg  [15:0] ram_rdata,
  output reg         ram_ack
);
  reg [15:0] mem [0:65535];
  reg [1:0]  wait_reg = 2'h0;
  integer    reads = 0;
  integer    writes = 0;
  initial ram_rdata = 16'h0000;
  initial ram_ack = 1'b0;
  // read data flips outside the ack cycle so a stale sample cannot match
  always @(posedge clk) begin
    ram_ack <= 1'b0;
    ram_rdata <= ~ram_rdata;
    if ((ram_re || ram_we) && !ram_ack) begin
      if (slow && wait_reg != 2'h3)
        wait_reg <= wait_reg + 2'h1;
      else begin
        wait_reg <= 2'h0;
        ram_ack <= 1'b1;
        if (ram_we) begin
          mem[ram_addr] <= ram_wdata;
          writes <= writes + 1;
        end else begin
          ram_rdata <= mem[ram_addr];
          reads <= reads + 1;
        end
      end
    end
  end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         enable = 1'b0;
  reg         combined_mode = 1'b0;
  reg         area_b = 1'b0;
  reg         isq_enable = 1'b1;
  reg         word_is_cmd_sync = 1'b0;
  reg         word_valid = 1'b0;
  reg         bus_idle = 1'b1;
  reg         slow = 1'b0;
  reg  [1:0]  isq_filter = 2'h1;
  reg  [4:0]  own_rt_addr = 5'h05;
  reg  [4:0]  int_mask = 5'h01;
  reg  [15:0] word_data = 16'h0000;
  reg         ram_parity_err = 1'b0;
  reg  [15:0] ram_parity_addr = 16'h0000;
  wire [15:0] ram_addr, ram_wdata, ram_rdata;
  wire        ram_we, ram_re, ram_ack, irq, busy;
  wire [4:0]  event_pulse;
  integer     fail_count = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     eom_count = 0;
  integer     irq_count = 0;
  integer     base;
  always #2.5 clk = ~clk;
  selective_message_monitor u_selective_message_monitor (
    .clk(clk), .resetn(resetn), .enable(enable), .combined_mode(combined_mode),
    .own_rt_addr(own_rt_addr), .area_b(area_b), .cmd_stack_size(2'h1),
    .data_stack_size(3'h1), .isq_enable(isq_enable), .isq_filter(isq_filter),
    .int_mask(int_mask), .word_data(word_data), .word_is_cmd_sync(word_is_cmd_sync),
    .word_valid(word_valid), .word_error(1'b0), .bus_idle(bus_idle),
    .ram_parity_err(ram_parity_err), .ram_parity_addr(ram_parity_addr), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata),
    .ram_ack(ram_ack), .irq(irq), .event_pulse(event_pulse), .busy(busy));
  smm_ram u_smm_ram (.clk(clk), .slow(slow), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata), .ram_ack(ram_ack));
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (event_pulse[0] === 1'b1)
      eom_count <= eom_count + 1;
    if (irq === 1'b1)
      irq_count <= irq_count + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task send(input [15:0] w, input c);
    begin
      @(posedge clk);
      word_data <= w;
      word_is_cmd_sync <= c;
      word_valid <= 1'b1;
      bus_idle <= 1'b0;
      @(posedge clk);
      word_valid <= 1'b0;
      repeat (30) @(posedge clk);
    end
  endtask
  task end_msg(input [8*8-1:0] name);
    integer n;
    begin
      @(posedge clk);
      bus_idle <= 1'b1;
      n = 0;
      repeat (3) @(posedge clk);
      while (busy !== 1'b0 && n < 500) begin
        @(posedge clk);
        n = n + 1;
      end
      check(busy, 16'h0000);
      $display("test %0s done", name);
    end
  endtask
  initial begin
    u_smm_ram.mem[16'h0102] = 16'h0400;
    u_smm_ram.mem[16'h0103] = 16'h0800;
    u_smm_ram.mem[16'h0106] = 16'h0600;
    u_smm_ram.mem[16'h0107] = 16'h0c00;
    u_smm_ram.mem[16'h0294] = 16'h0008;
    u_smm_ram.mem[16'h02a7] = 16'h0002;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check(u_smm_ram.reads[15:0], 16'h0000);
    enable <= 1'b1;
    // receive, rt 5 sa 3, two data words then status
    send(16'h2862, 1'b1);
    send(16'h1111, 1'b0);
    send(16'h2222, 1'b0);
    send(16'h2800, 1'b1);
    end_msg("rx");
    check(u_smm_ram.mem[16'h0800], 16'h1111);
    check(u_smm_ram.mem[16'h0801], 16'h2222);
    check(u_smm_ram.mem[16'h0802], 16'h2800);
    check(u_smm_ram.mem[16'h0403], 16'h2862);
    check(u_smm_ram.mem[16'h0103], 16'h0803);
    check(u_smm_ram.mem[16'h0102], 16'h0404);
    check(eom_count[15:0], 16'h0001);
    check(irq_count[15:0], 16'h0001);
    check(u_smm_ram.mem[16'h0040], 16'h0001);
    check(u_smm_ram.mem[16'h0041], 16'h2862);
    // sa 4 disabled; its status word is then seen as a disabled command too
    base = u_smm_ram.writes;
    send(16'h2881, 1'b1);
    send(16'h3333, 1'b0);
    send(16'h2800, 1'b1);
    end_msg("off");
    check(u_smm_ram.writes - base, 16'h0000);
    // own address skipped in combined mode
    combined_mode <= 1'b1;
    base = u_smm_ram.reads;
    send(16'h2862, 1'b1);
    send(16'h4444, 1'b0);
    send(16'h2800, 1'b1);
    end_msg("own");
    check(u_smm_ram.reads - base, 16'h0000);
    // transmit, rt 9 sa 17, area b, slow ram, eom masked
    combined_mode <= 1'b0;
    area_b <= 1'b1;
    slow <= 1'b1;
    int_mask <= 5'h00;
    send(16'h4e21, 1'b1);
    send(16'h4800, 1'b1);
    send(16'h5555, 1'b0);
    end_msg("tx");
    check(u_smm_ram.mem[16'h0c00], 16'h4800);
    check(u_smm_ram.mem[16'h0c01], 16'h5555);
    check(u_smm_ram.mem[16'h0603], 16'h4e21);
    check(u_smm_ram.mem[16'h0107], 16'h0c02);
    check(u_smm_ram.mem[16'h0106], 16'h0604);
    check(irq_count[15:0], 16'h0001);
    check(u_smm_ram.mem[16'h0042], 16'h0001);
    check(u_smm_ram.mem[16'h0043], 16'h4e21);
    // rt-to-rt into rt 5 sa 3, area a, command stack wraps at its end
    area_b <= 1'b0;
    int_mask <= 5'h04;
    u_smm_ram.mem[16'h0102] = 16'h07fc;
    send(16'h2862, 1'b1);
    send(16'h4c62, 1'b1);
    send(16'h4800, 1'b1);
    send(16'h6666, 1'b0);
    send(16'h7777, 1'b0);
    send(16'h2800, 1'b1);
    end_msg("rtrt");
    check(u_smm_ram.mem[16'h0803], 16'h4c62);
    check(u_smm_ram.mem[16'h0804], 16'h4800);
    check(u_smm_ram.mem[16'h0807], 16'h2800);
    check(u_smm_ram.mem[16'h07ff], 16'h2862);
    check(u_smm_ram.mem[16'h0102], 16'h0400);
    check(u_smm_ram.mem[16'h0103], 16'h0808);
    check(irq_count[15:0], 16'h0002);
    check(eom_count[15:0], 16'h0001);
    // ram parity error logged as a two-word queue entry
    @(posedge clk);
    ram_parity_addr <= 16'h1234;
    ram_parity_err <= 1'b1;
    @(posedge clk);
    ram_parity_err <= 1'b0;
    repeat (40) @(posedge clk);
    check(u_smm_ram.mem[16'h0046], 16'h0004);
    check(u_smm_ram.mem[16'h0047], 16'h1234);
    $display("test parity done");
    stop_test;
  end
endmodule
